// ### nvmem_host.sv
// host-side controller that sequences reads and writes on the memory pins
// assumes supply_ok reports the supply above its minimum, synchronous to CLK
`timescale 1ns/10ps
//Contract
// [RULE1] 2M byte locations, 21-bit address, 8-bit data
// [RULE2] chip select high floats and ignores controls
// [RULE3] select plus strobes choose read or write
// [RULE4] writes blocked below low_supply_limit
// [RULE5] no access until 2 ms after supply
// [RULE6] hold select and strobe high during startup
// [RULE7] pull-ups keep select and strobe high
// [RULE8] restart startup wait after brownout
// [RULE9] read returns last byte written
module nvmem_host #(
    parameter int STARTUP_CYCLES = nvmem_host_pkg::STARTUP_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SUPPLY_OK,
    input wire logic REQ_VALID,
    input wire nvmem_host_pkg::req_s REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [nvmem_host_pkg::DATA_W-1:0] RSP_DATA,
    output logic [nvmem_host_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic MEM_SEL_N,
    output logic MEM_WR_N,
    output logic MEM_OUT_N,
    input wire logic [nvmem_host_pkg::DATA_W-1:0] MEM_DQ_I,
    output logic [nvmem_host_pkg::DATA_W-1:0] MEM_DQ_O,
    output logic MEM_DQ_OE
);
    import nvmem_host_pkg::*;

    state_e state_r;
    logic [CNT_W-1:0] boot_cnt_r;
    logic [CNT_W-1:0] acc_cnt_r;
    logic wr_r;

    // startup counter restarts whenever the supply drops
    always_ff @(posedge CLK) begin
        if (!RESET_N || !SUPPLY_OK) begin
            boot_cnt_r <= '0; // see [RULE8]
        end else if (state_r == ST_WAIT) begin
            boot_cnt_r <= boot_cnt_r + 1'b1; // see [RULE5]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || !SUPPLY_OK) begin
            state_r <= ST_WAIT; // see [RULE8]
            acc_cnt_r <= '0;
            wr_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_WAIT: begin
                    if (boot_cnt_r >= CNT_W'(STARTUP_CYCLES - 1)) begin
                        state_r <= ST_IDLE; // see [RULE5]
                    end
                end
                ST_IDLE: begin
                    if (REQ_VALID) begin
                        state_r <= ST_ACC;
                        wr_r <= REQ.write;
                        acc_cnt_r <= '0;
                    end
                end
                ST_ACC: begin
                    acc_cnt_r <= acc_cnt_r + 1'b1;
                    if (acc_cnt_r >= CNT_W'(ACCESS_CYC - 1)) begin
                        state_r <= ST_END;
                    end
                end
                ST_END: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // pin drive; controls stay high outside an access
    always_ff @(posedge CLK) begin
        if (!RESET_N || !SUPPLY_OK) begin
            MEM_SEL_N <= 1'b1; // see [RULE6] [RULE7]
            MEM_WR_N <= 1'b1; // see [RULE6] [RULE7]
            MEM_OUT_N <= 1'b1;
            MEM_DQ_OE <= 1'b0;
            MEM_ADDR <= '0;
            MEM_DQ_O <= '0;
        end else if (state_r == ST_IDLE && REQ_VALID) begin
            MEM_ADDR <= REQ.addr; // see [RULE1]
            MEM_DQ_O <= REQ.wdata;
            MEM_SEL_N <= 1'b0; // see [RULE3]
            MEM_WR_N <= !REQ.write;
            MEM_OUT_N <= REQ.write;
            MEM_DQ_OE <= REQ.write;
        end else if (state_r == ST_ACC && acc_cnt_r >= CNT_W'(ACCESS_CYC - 1)) begin
            // write ends on strobe rise while data and address still held
            MEM_WR_N <= 1'b1; // see [RULE9]
            MEM_OUT_N <= 1'b1;
        end else if (state_r == ST_END) begin
            MEM_SEL_N <= 1'b1; // see [RULE2]
            MEM_DQ_OE <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || !SUPPLY_OK) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= '0;
        end else if (state_r == ST_ACC && acc_cnt_r >= CNT_W'(ACCESS_CYC - 1)) begin
            RSP_VALID <= 1'b1;
            if (!wr_r) begin
                RSP_DATA <= MEM_DQ_I; // see [RULE3]
            end
        end else begin
            RSP_VALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N || !SUPPLY_OK) begin
            REQ_READY <= 1'b0;
        end else begin
            REQ_READY <= (state_r == ST_WAIT && boot_cnt_r >= CNT_W'(STARTUP_CYCLES - 1))
                || state_r == ST_END;
        end
    end

    AST_STARTUP_QUIET: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE6]
        state_r == ST_WAIT |-> MEM_SEL_N && MEM_WR_N)
        else $error("controls not high during startup");

    AST_BROWNOUT: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE8]
        !SUPPLY_OK |=> state_r == ST_WAIT && boot_cnt_r == '0)
        else $error("startup wait not restarted");

    AST_WRITE_DRIVES: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE3]
        !MEM_WR_N |-> !MEM_SEL_N && MEM_DQ_OE)
        else $error("write strobe without select or data drive");

    AST_READ_FLOAT: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE2]
        !MEM_OUT_N |-> !MEM_DQ_OE && MEM_WR_N)
        else $error("host drives bus during read");

    AST_ACCESS_LEN: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE9]
        $fell(MEM_SEL_N) |-> !MEM_SEL_N [*2] ##1 $rose(MEM_SEL_N))
        else $error("access length wrong");

    AST_RSP: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE5]
        $fell(MEM_SEL_N) |-> ##1 RSP_VALID ##1 !RSP_VALID)
        else $error("response not one pulse after access");

    AST_ADDR_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE1]
        !MEM_SEL_N && !$rose(MEM_SEL_N) && $past(!MEM_SEL_N) |-> $stable(MEM_ADDR))
        else $error("address moved in access");

    AST_NO_EARLY: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE5]
        state_r == ST_WAIT |-> !REQ_READY && !RSP_VALID && !MEM_DQ_OE)
        else $error("access during startup");

    AST_STROBE_EXCL: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE3]
        !MEM_WR_N |-> MEM_OUT_N)
        else $error("output drive low during write");

    AST_SEL_IDLE: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE2]
        MEM_SEL_N |-> MEM_WR_N && MEM_OUT_N && !MEM_DQ_OE)
        else $error("strobes or data active while unselected");

    AST_WR_PULSE: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE9]
        $fell(MEM_WR_N) |=> $rose(MEM_WR_N))
        else $error("write pulse not one cycle");

    AST_DATA_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE9]
        !MEM_WR_N |=> $stable(MEM_DQ_O) && MEM_DQ_OE)
        else $error("write data not held past strobe rise");

    AST_READY_PULSE: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE5]
        REQ_READY |=> !REQ_READY)
        else $error("ready longer than one cycle");

    AST_RSP_SELECTED: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE3]
        RSP_VALID |-> MEM_WR_N && !MEM_SEL_N)
        else $error("response outside the access");

    AST_ACC_FROM_IDLE: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE5]
        $fell(MEM_SEL_N) |-> $past(state_r == ST_IDLE))
        else $error("access started outside idle");

    AST_BOOT_RANGE: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE5]
        state_r == ST_WAIT |-> boot_cnt_r <= CNT_W'(STARTUP_CYCLES - 1))
        else $error("startup counter overran");

    AST_OE_NEEDS_SEL: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE2]
        MEM_DQ_OE |-> !MEM_SEL_N)
        else $error("data driven while unselected");

    AST_RSP_NEEDS_ACC: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE3]
        RSP_VALID |-> $past(state_r == ST_ACC))
        else $error("response without access");

    AST_READY_NOT_BUSY: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE5]
        REQ_READY |-> MEM_SEL_N)
        else $error("ready while selected");

    AST_SUPPLY_QUIET: assert property (@(posedge CLK) disable iff (!RESET_N) // see [RULE8]
        !SUPPLY_OK |=> MEM_SEL_N && MEM_WR_N && !MEM_DQ_OE)
        else $error("pins active after supply loss");

    AST_END_STATE: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE3]
        state_r == ST_END |=> state_r == ST_IDLE)
        else $error("access end did not return to idle");

    AST_WRITE_END: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE9]
        $rose(MEM_WR_N) |-> !MEM_SEL_N && MEM_DQ_OE)
        else $error("write ended without select or data");

    AST_READ_CAPTURE: assert property (@(posedge CLK) disable iff (!RESET_N || !SUPPLY_OK) // see [RULE9]
        RSP_VALID && !wr_r |-> RSP_DATA == $past(MEM_DQ_I))
        else $error("read byte not taken from bus");
endmodule

// ### nvmem_host_pkg.sv
// package for the host-side controller of a byte-wide asynchronous non-volatile memory
// assumes a 25 MHz system clock and a memory with sram-style active-low controls
package nvmem_host_pkg;
    localparam int CLK_MHZ = 25;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    localparam int STARTUP_MS = 2;
    localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
    localparam int ACCESS_NS = 40;
    localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
    } req_s;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_ACC = 2'b11,
        ST_END = 2'b10
    } state_e;
endpackage

// ### nvmem_host_tb.sv
// self-checking bench for the host controller against the byte memory model
// assumes nvmem_host and nvmem_model are compiled first
`timescale 1ns/10ps
module nvmem_host_tb;
    import nvmem_host_pkg::*;
    logic clk = 0, rst_n = 0, pwr = 1, req_valid = 0, req_ready, rsp_valid;
    logic sel_n, wr_n, out_n, oe;
    req_s req = '0;
    logic [7:0] rsp_data, dq_o, dq_m, bus, q;
    logic [20:0] addr;
    int n_mismatch = 0, n_compared = 0;
    assign bus = oe ? dq_o : dq_m;
    initial forever #20 clk = ~clk;
    nvmem_host #(.STARTUP_CYCLES(20)) DUT (.CLK(clk), .RESET_N(rst_n), .SUPPLY_OK(pwr),
        .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .MEM_ADDR(addr), .MEM_SEL_N(sel_n), .MEM_WR_N(wr_n),
        .MEM_OUT_N(out_n), .MEM_DQ_I(bus), .MEM_DQ_O(dq_o), .MEM_DQ_OE(oe));
    nvmem_model mdl (.ADDR(addr), .SEL_N(sel_n), .WR_N(wr_n), .OUT_N(out_n),
        .PWR_OK(pwr), .DQ_IN(bus), .DQ(dq_m));
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // pins stay idle and no request is accepted while the startup wait runs
    task automatic quiet();
        repeat (19) begin
            step();
            chk({req_ready, sel_n, wr_n, out_n}, 8'h07);
        end
    endtask
    task automatic acc(input logic w, input logic [20:0] a, input logic [7:0] d);
        int i;
        req = '{a, d, w};
        req_valid = 1;
        for (i = 0; i < 99 && !rsp_valid; i++) begin
            step();
            if (!sel_n && req_valid) begin
                chk({oe, wr_n}, {6'h00, w, !w});
                req_valid = 0;
            end
        end
        if (!rsp_valid) begin
            n_mismatch++;
            conclude();
        end
        q = rsp_data;
        step();
        chk({7'h00, req_ready}, 8'h01);
    endtask
    task automatic t_start();
        req_valid = 1;
        quiet();
        acc(1, 21'h1f_ffff, 8'ha5);
        acc(1, 21'h0_0000, 8'h3c);
        acc(0, 21'h1f_ffff, 8'h00);
        chk(q, 8'ha5);
        acc(0, 21'h0_0000, 8'h00);
        chk(q, 8'h3c);
        $display("startup and access test done");
    endtask
    task automatic t_brown();
        pwr = 0;
        repeat (3) step();
        pwr = 1;
        quiet();
        acc(0, 21'h1f_ffff, 8'h00);
        chk(q, 8'ha5);
        $display("brownout test done");
    endtask
    initial begin
        repeat (5) step();
        rst_n = 1;
        t_start();
        t_brown();
        conclude();
    end
endmodule

// ### nvmem_model.sv
// behavioural byte memory that answers the host controller's pins
// assumes active-low select, write strobe and output drive, no pull-ups on data
`timescale 1ns/10ps
module nvmem_model
    import nvmem_host_pkg::*;
(
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic SEL_N,
    input wire logic WR_N,
    input wire logic OUT_N,
    input wire logic PWR_OK,
    input wire logic [DATA_W-1:0] DQ_IN,
    output logic [DATA_W-1:0] DQ
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] cur;
    // a released bus shows the inverse rather than a stale copy
    always @* begin
        cur = mem.exists(ADDR) ? mem[ADDR] : 8'h00;
        // a floating select reads as high, as its pull-up would make it
        DQ = (SEL_N === 1'b0 && WR_N && !OUT_N) ? cur : ~cur;
    end
    // store at strobe end, never while the supply is low
    always @(posedge WR_N) begin
        if (SEL_N === 1'b0 && PWR_OK) mem[ADDR] = DQ_IN;
    end
endmodule
